// ==== trig_pkg.sv ====
// Purpose: shared constants for the channel level trigger recorder
// Assumes: 32-bit APB, 12-bit byte address, signed converter samples
// Notes: one word per register, reserved bits read as zero
package trig_pkg;
  localparam int NCH = 4;
  localparam int SW = 16;
  localparam int AW = SW + 1;
  localparam int XW = SW + 2;
  localparam int DLY = 4;
  localparam int NSTS = NCH + 1;
  localparam int PAW = 12;

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STS = 12'h004;
  localparam logic [11:0] OFS_MASK = 12'h008;
  localparam logic [11:0] OFS_ARMED = 12'h00C;
  localparam logic [11:0] OFS_CH_BASE = 12'h040;
  localparam int CH_IDX_LSB = 4;
  localparam int CH_REG_LSB = 2;
  localparam logic [1:0] CH_CFG = 2'h0;
  localparam logic [1:0] CH_LVLP = 2'h1;
  localparam logic [1:0] CH_LVLS = 2'h2;
  localparam logic [1:0] CH_HYST = 2'h3;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT_EN = 1;
  localparam int CTRL_EXT_FALL = 2;
  localparam int CTRL_MAN = 3;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_NEG = 2;
  localparam int CFG_SLOPE = 3;
  localparam int STS_REC = 0;
  localparam int STS_CH_LSB = 1;

  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [NSTS-1:0] MASK_RST = 5'h00;
  localparam logic [SW-1:0] LVL_RST = 16'h0000;
  localparam logic [SW-1:0] HYST_RST = 16'h0000;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_BASIC = 2'h1,
    MODE_DUAL = 2'h2
  } trig_mode_e;
endpackage

// ==== lvl_det.sv ====
// Purpose: single-level crossing detector with hysteresis re-arm
// Assumes: value and level are signed, hysteresis is unsigned
// Notes: positive direction means rising through the level
`timescale 1ns/1ps
module lvl_det (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_vld,
  input wire logic i_clr,
  input wire logic i_en,
  input wire logic i_neg,
  input wire logic signed [trig_pkg::AW-1:0] i_val,
  input wire logic signed [trig_pkg::SW-1:0] i_lvl,
  input wire logic [trig_pkg::SW-1:0] i_hyst,
  output logic o_trig,
  output logic o_armed
);
  import trig_pkg::*;

  // widened so level +/- hysteresis never wraps
  wire logic signed [XW-1:0] v = XW'(i_val);
  wire logic signed [XW-1:0] l = XW'(i_lvl);
  wire logic signed [XW-1:0] h = $signed({2'h0, i_hyst});
  wire logic above = v > l;
  wire logic below = v < l;
  // equal samples are neither side, so they never fire
  wire logic beyond = i_neg ? below : above;
  wire logic rearm = i_neg ? (v > l + h) : (v < l - h);
  wire logic step = i_vld & i_en & ~i_clr;
  wire logic fire = step & o_armed & beyond;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_trig <= 1'b0;
      o_armed <= 1'b0;
    end else if (i_ce) begin
      o_trig <= fire;
      if (i_clr || !i_en) begin
        o_armed <= 1'b0;
      end else if (fire) begin
        o_armed <= 1'b0;
      end else if (step && rearm) begin
        o_armed <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_fire;
    $past(i_ce) && o_trig;
  endsequence

  AST_EQUAL_NO_FIRE: assert property (
    (i_ce && step && v == l) |=> !o_trig)
    else $error("sample equal to level fired");
  AST_FIRE_CAUSE: assert property (
    s_fire |-> $past(beyond) && $past(o_armed))
    else $error("fired without armed beyond sample");
  AST_DISARM: assert property (
    s_fire |-> !o_armed)
    else $error("still armed after firing");
  AST_CLEAR: assert property (
    (i_ce && i_clr) |=> !o_armed && !o_trig)
    else $error("clear left detector armed");
endmodule // lvl_det

// ==== trig_rec.sv ====
// Purpose: per-channel digital trigger detectors and recorder trigger
// Assumes: samples on i_mclk qualified by i_smp_vld; APB slave
// Notes: pready answers in the first cycle of the access phase, no wait states
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module trig_rec (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_smp_vld,
  input wire logic [trig_pkg::NCH*trig_pkg::SW-1:0] i_smp,
  input wire logic i_ext_trig,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [trig_pkg::PAW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_trig,
  output logic [trig_pkg::NCH-1:0] o_ch_trig,
  output logic o_irq
);
  import trig_pkg::*;

  function automatic logic signed [AW-1:0] sx(input logic [SW-1:0] s);
    sx = AW'($signed(s));
  endfunction

  logic [2:0] ctrl_r;
  logic [NSTS-1:0] sts_r;
  logic [NSTS-1:0] sts_nxt;
  logic [NSTS-1:0] mask_r;
  logic [3:0] cfg_r [NCH];
  logic [SW-1:0] lvlp_r [NCH];
  logic [SW-1:0] lvls_r [NCH];
  logic [SW-1:0] hyst_r [NCH];
  logic [DLY-1:0][SW-1:0] dly_r [NCH];
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic [31:0] rdata_w;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic setup_w = i_psel & ~i_penable;
  wire logic acc_w = i_psel & i_penable & o_pready;
  wire logic wr_w = acc_w & i_pwrite;
  wire logic rd_w = acc_w & ~i_pwrite;
  wire logic hit_ctrl = i_paddr == OFS_CTRL;
  wire logic hit_sts = i_paddr == OFS_STS;
  wire logic hit_mask = i_paddr == OFS_MASK;
  wire logic hit_arm = i_paddr == OFS_ARMED;
  wire logic hit_ch = (i_paddr[PAW-1:6] == OFS_CH_BASE[PAW-1:6]) && (i_paddr[1:0] == 2'h0);
  wire logic [1:0] ch_idx = i_paddr[CH_IDX_LSB +: 2];
  wire logic [1:0] reg_idx = i_paddr[CH_REG_LSB +: 2];
  wire logic hit_w = hit_ctrl | hit_sts | hit_mask | hit_arm | hit_ch;

  wire logic run_w = ctrl_r[CTRL_RUN];
  wire logic man_w = wr_w & hit_ctrl & i_pwdata[CTRL_MAN];
  // edge taken from the second and third stage, never the first
  wire logic ext_rise = ext_s2_r & ~ext_s3_r;
  wire logic ext_fall = ~ext_s2_r & ext_s3_r;
  wire logic ext_edge_w = ctrl_r[CTRL_EXT_EN] &
                          (ctrl_r[CTRL_EXT_FALL] ? ext_fall : ext_rise);

  logic [NCH-1:0] ch_trig_w;
  logic [NCH-1:0] arm_p_w;
  logic [NCH-1:0] arm_s_w;
  wire logic rec_trig_w = run_w & ((|ch_trig_w) | man_w | ext_edge_w);
  // only the bits shown by the read are cleared, later events survive
  wire logic [NSTS-1:0] sts_clr_w = (rd_w & hit_sts) ? o_prdata[NSTS-1:0] : '0;
  wire logic [NSTS-1:0] sts_set_w = run_w ? {ch_trig_w, rec_trig_w} : '0;

  assign sts_nxt = (sts_r & ~sts_clr_w) | sts_set_w;

  ////////////////////////////////////////////////////////////////////////
  // per-channel datapath
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire logic [SW-1:0] smp = i_smp[c*SW +: SW];
    wire logic [1:0] mode = cfg_r[c][CFG_MODE_LSB +: 2];
    wire logic neg = cfg_r[c][CFG_NEG];
    wire logic en_p = run_w & (mode == MODE_BASIC || mode == MODE_DUAL);
    wire logic en_s = run_w & (mode == MODE_DUAL);
    wire logic signed [AW-1:0] alu = cfg_r[c][CFG_SLOPE] ?
      sx(smp) - sx(dly_r[c][DLY-1]) : sx(smp);
    logic trig_p;
    logic trig_s;

    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        dly_r[c] <= '0;
      end else if (i_ce && !run_w) begin
        dly_r[c] <= '0;
      end else if (i_ce && i_smp_vld) begin
        dly_r[c] <= {dly_r[c][DLY-2:0], smp};
      end
    end

    lvl_det u_pri (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_vld(i_smp_vld),
      .i_clr(~run_w),
      .i_en(en_p),
      .i_neg(neg),
      .i_val(alu),
      .i_lvl(lvlp_r[c]),
      .i_hyst(hyst_r[c]),
      .o_trig(trig_p),
      .o_armed(arm_p_w[c])
    );

    // secondary mirrors the primary direction and shares its band
    lvl_det u_sec (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_vld(i_smp_vld),
      .i_clr(~run_w),
      .i_en(en_s),
      .i_neg(~neg),
      .i_val(alu),
      .i_lvl(lvls_r[c]),
      .i_hyst(hyst_r[c]),
      .o_trig(trig_s),
      .o_armed(arm_s_w[c])
    );

    assign ch_trig_w[c] = trig_p | trig_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_w = '0;
    if (hit_ctrl) begin
      rdata_w[2:0] = ctrl_r;
    end else if (hit_sts) begin
      rdata_w[NSTS-1:0] = sts_r;
    end else if (hit_mask) begin
      rdata_w[NSTS-1:0] = mask_r;
    end else if (hit_arm) begin
      rdata_w[2*NCH-1:0] = {arm_s_w, arm_p_w};
    end else if (hit_ch) begin
      case (reg_idx)
        CH_CFG: rdata_w[3:0] = cfg_r[ch_idx];
        CH_LVLP: rdata_w[SW-1:0] = lvlp_r[ch_idx];
        CH_LVLS: rdata_w[SW-1:0] = lvls_r[ch_idx];
        CH_HYST: rdata_w[SW-1:0] = hyst_r[ch_idx];
        default: rdata_w = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave and register writes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else if (i_ce) begin
      o_pready <= setup_w;
      o_pslverr <= setup_w & ~hit_w;
      o_prdata <= (setup_w && !i_pwrite) ? rdata_w : '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
    end else if (i_ce && wr_w) begin
      if (hit_ctrl) begin
        ctrl_r <= i_pwdata[2:0];
      end
      if (hit_mask) begin
        mask_r <= i_pwdata[NSTS-1:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        cfg_r[c] <= CFG_RST;
        lvlp_r[c] <= LVL_RST;
        lvls_r[c] <= LVL_RST;
        hyst_r[c] <= HYST_RST;
      end
    end else if (i_ce && wr_w && hit_ch) begin
      case (reg_idx)
        CH_CFG: cfg_r[ch_idx] <= i_pwdata[3:0];
        CH_LVLP: lvlp_r[ch_idx] <= i_pwdata[SW-1:0];
        CH_LVLS: lvls_r[ch_idx] <= i_pwdata[SW-1:0];
        CH_HYST: hyst_r[ch_idx] <= i_pwdata[SW-1:0];
        default: cfg_r[ch_idx] <= cfg_r[ch_idx];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external pin sync, trigger outputs, status and interrupt
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else if (i_ce) begin
      ext_s1_r <= i_ext_trig;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_trig <= 1'b0;
      o_ch_trig <= '0;
      sts_r <= '0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_trig <= rec_trig_w;
      o_ch_trig <= run_w ? ch_trig_w : '0;
      sts_r <= sts_nxt;
      o_irq <= |(sts_nxt & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_ch_fire;
    $past(i_ce) && (|o_ch_trig);
  endsequence

  AST_OR_TRIG: assert property (
    s_ch_fire |-> o_trig)
    else $error("channel trigger not passed to recorder");
  AST_OFF_SILENT: assert property (
    (cfg_r[0][1:0] == MODE_OFF)[*3] |-> !o_ch_trig[0])
    else $error("disabled channel produced a trigger");
  AST_MANUAL: assert property (
    (i_ce && man_w && run_w) |=> o_trig)
    else $error("manual request ignored");
  AST_EXTERNAL: assert property (
    (i_ce && run_w && ctrl_r[CTRL_EXT_EN] && !ctrl_r[CTRL_EXT_FALL] &&
     ext_s2_r && !ext_s3_r) |=> o_trig)
    else $error("external rising edge ignored");
  AST_DELAY: assert property (
    (i_ce && i_smp_vld && run_w) |=> dly_r[0][0] == $past(i_smp[SW-1:0]))
    else $error("delay register missed a sample");
  AST_STOP_QUIET: assert property (
    (i_ce && !run_w)[*2] |=> !o_trig && o_ch_trig == '0)
    else $error("trigger while not recording");
  AST_IRQ: assert property (
    (i_ce && (|(sts_nxt & mask_r))) |=> o_irq)
    else $error("unmasked status did not raise interrupt");
endmodule // trig_rec

// ==== adc_model.sv ====
// Purpose: converter sample stream model for the trigger recorder
// Assumes: one word per put, valid for exactly one cycle
// Notes: a released bus shows the inverse of the last word
`timescale 1ns/1ps
module adc_model (
  input wire logic i_mclk,
  output logic o_vld,
  output logic [trig_pkg::NCH*trig_pkg::SW-1:0] o_smp
);
  initial begin
    o_vld = 1'b0;
    o_smp = '0;
  end
  task automatic put(input logic [trig_pkg::NCH*trig_pkg::SW-1:0] v, input int gap);
    @(posedge i_mclk);
    o_smp <= v;
    o_vld <= 1'b1;
    @(posedge i_mclk);
    o_vld <= 1'b0;
    // stale word must not pass for the held sample
    o_smp <= ~v;
    repeat (gap + 3) @(posedge i_mclk);
  endtask
endmodule // adc_model

// ==== tb_digital_level_trigger_detector.sv ====
// Purpose: self-checking bench for the channel trigger recorder
// Assumes: pready answers within the watchdog span
// Notes: expected pulses are queued by the driver, popped by the monitor
`timescale 1ns/1ps
module tb_digital_level_trigger_detector;
  import trig_pkg::*;
  logic i_mclk, i_rst_n, i_ce, i_smp_vld, i_ext_trig, i_psel, i_penable, i_pwrite;
  logic [PAW-1:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_trig, o_irq;
  logic [NCH*SW-1:0] i_smp;
  logic [NCH-1:0] o_ch_trig, on_m;
  logic [NCH-1:0] expq[$];
  logic [SW-1:0] cur[NCH];
  int err_count, n_tests;
  trig_rec i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_smp_vld(i_smp_vld),
    .i_smp(i_smp), .i_ext_trig(i_ext_trig), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_trig(o_trig), .o_ch_trig(o_ch_trig),
    .o_irq(o_irq));
  adc_model i_adc (.i_mclk(i_mclk), .o_vld(i_smp_vld), .o_smp(i_smp));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) fail($sformatf("read %h expected %h", g, e));
  endtask
  task automatic chk_lvl(input logic g, input logic e);
    n_tests++;
    if (g !== e) fail($sformatf("level %b expected %b", g, e));
  endtask
  task automatic chk_trig(input logic [NCH:0] g, input logic [NCH:0] e);
    n_tests++;
    if (g !== e) fail($sformatf("trigger %b expected %b", g, e));
  endtask
  task automatic apb(input logic w, input logic [PAW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [PAW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [PAW-1:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk_rd(q, x);
    chk_lvl(e, xe);
  endtask
  function automatic logic [PAW-1:0] cha(input int c, input logic [1:0] r);
    return OFS_CH_BASE + PAW'(c << CH_IDX_LSB) + PAW'(r << CH_REG_LSB);
  endfunction
  // channels still off carry random traffic that must never trigger
  task automatic snd(input int c, input int v, input logic [NCH-1:0] e);
    logic [NCH*SW-1:0] w;
    cur[c] = SW'(v);
    for (int k = 0; k < NCH; k++) begin
      if (!on_m[k]) cur[k] = SW'($urandom);
      w[k*SW +: SW] = cur[k];
    end
    if (e != 0) expq.push_back(e);
    i_adc.put(w, $urandom_range(2));
  endtask
  task automatic settle();
    repeat (2) @(negedge i_mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (i_rst_n && (o_trig === 1'b1 || o_ch_trig !== 4'h0)) begin
      if (expq.size() == 0) fail("unexpected trigger");
      else chk_trig({o_trig, o_ch_trig}, {1'b1, expq.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    fail("watchdog expired");
    summarize();
  end
  initial begin
    void'($urandom(32'hab27));
    {i_rst_n, i_ext_trig, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    i_ce = 1'b1;
    on_m = 4'h7;
    foreach (cur[k]) cur[k] = '0;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(OFS_CTRL, 32'h0, 1'b0);
    rd(OFS_STS, 32'h0, 1'b0);
    rd(OFS_ARMED, 32'h0, 1'b0);
    rd(12'h800, 32'h0, 1'b1);
    wr(cha(0, CH_CFG), 32'h1);
    wr(cha(0, CH_LVLP), 32'h64);
    wr(cha(0, CH_HYST), 32'hA);
    wr(cha(1, CH_CFG), 32'h5);
    wr(cha(1, CH_LVLP), 32'h0000FFCE);
    wr(cha(2, CH_CFG), 32'h2);
    wr(cha(2, CH_LVLP), 32'h64);
    wr(cha(2, CH_LVLS), 32'h0000FF9C);
    wr(cha(2, CH_HYST), 32'h5);
    wr(cha(3, CH_CFG), 32'h3);
    rd(cha(2, CH_LVLS), 32'h0000FF9C, 1'b0);
    wr(OFS_MASK, 32'h2);
    wr(OFS_CTRL, 32'h1);
    snd(0, 200, 0);
    snd(0, 95, 0);
    snd(0, 100, 0);
    snd(0, 80, 0);
    snd(0, 100, 0);
    snd(0, 101, 1);
    snd(0, 95, 0);
    snd(0, 150, 0);
    snd(0, 85, 0);
    // frozen by the enable: the beyond sample is never taken
    i_ce <= 1'b0;
    snd(0, 150, 0);
    i_ce <= 1'b1;
    snd(0, 150, 1);
    settle();
    chk_lvl(o_irq, 1'b1);
    rd(OFS_STS, 32'h3, 1'b0);
    settle();
    chk_lvl(o_irq, 1'b0);
    snd(1, -50, 0);
    snd(1, -51, 2);
    settle();
    chk_lvl(o_irq, 1'b0);
    rd(OFS_STS, 32'h5, 1'b0);
    snd(2, 101, 4);
    snd(2, 0, 0);
    snd(2, -101, 4);
    snd(0, 80, 0);
    expq.push_back(4'h0);
    wr(OFS_CTRL, 32'h9);
    rd(OFS_CTRL, 32'h1, 1'b0);
    wr(OFS_CTRL, 32'h3);
    expq.push_back(4'h0);
    i_ext_trig <= 1'b1;
    repeat (10) @(posedge i_mclk);
    wr(OFS_CTRL, 32'h7);
    expq.push_back(4'h0);
    i_ext_trig <= 1'b0;
    repeat (10) @(posedge i_mclk);
    wr(OFS_CTRL, 32'h2);
    i_ext_trig <= 1'b1;
    repeat (10) @(posedge i_mclk);
    wr(cha(3, CH_CFG), 32'h9);
    wr(cha(3, CH_LVLP), 32'h32);
    on_m[3] = 1'b1;
    cur[3] = '0;
    wr(OFS_CTRL, 32'h1);
    snd(0, 150, 0);
    for (int k = 0; k < 8; k++) snd(3, (k < 4) ? 30 : 60, 0);
    snd(3, 120, 8);
    repeat (10) @(posedge i_mclk);
    // second reset in mid-run must bring back the idle register state
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(OFS_CTRL, 32'h0, 1'b0);
    rd(cha(3, CH_CFG), 32'h0, 1'b0);
    rd(OFS_ARMED, 32'h0, 1'b0);
    chk_lvl(expq.size() == 0, 1'b1);
    summarize();
  end
endmodule // tb_digital_level_trigger_detector
